// >>> hw/ddr_cmd_pkg.sv
// Shared constants for the command and power-state logic of a DDR2 memory core.
// Assumes a single 40 MHz clock; all pins are sampled on its rising edge.
package ddr_cmd_pkg;
	// ************************************************************
	// Command codes {cs_n, ras_n, cas_n, we_n}
	// ************************************************************
	localparam logic [3:0] CMD_MRS = 4'h0;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_WR = 4'h4;
	localparam logic [3:0] CMD_RD = 4'h5;
	localparam logic [3:0] CMD_NOP = 4'h7;

	// ************************************************************
	// Power states, one-hot
	// ************************************************************
	typedef enum logic [3:0] {
		PW_ON = 4'h1,
		PW_APD = 4'h2,
		PW_PPD = 4'h4,
		PW_SREF = 4'h8
	} pwr_state_t;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_PS = 25000;
	localparam int T_XSNR_NS = 200;
	// Least time, so round up
	localparam int XSNR_CYC = (T_XSNR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int T_XSRD_CLK = 200;
	localparam int T_MRD_CLK = 2;
	localparam int CKE_MIN_CLK = 3;
	localparam int BURST_CLK_BL4 = 2;
	localparam int BURST_CLK_BL8 = 4;

	// ************************************************************
	// Mode register fields and codes
	// ************************************************************
	localparam int MR_BL_LSB = 0;
	localparam logic [2:0] MR_BL8_CODE = 3'h3;
	localparam int MR_AL_LSB = 3;
	localparam int MR_ODT_BIT_LO = 2;
	localparam int MR_ODT_BIT_HI = 6;
	localparam int MR_IDX_EMR1 = 1;
	localparam int AUTO_PRE_BIT = 10;
	localparam int COL_W = 10;
endpackage : ddr_cmd_pkg

// >>> hw/col_cmd_delay.sv
// Programmable delay line for column commands (additive latency).
// Assumes the caller keeps delay within 0..DEPTH.
`timescale 1ns/1ps
module col_cmd_delay #(
	parameter int W = 14,
	parameter int DEPTH = 5
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	input wire logic [2:0] delay,
	output logic out_valid,
	output logic [W-1:0] out_data
);
	logic [DEPTH:1] v_q;
	logic [W-1:0] d_q [1:DEPTH];

	if (DEPTH < 1 || DEPTH > 7)
	begin : g_bad_depth
		$error("col_cmd_delay: DEPTH must be 1..7");
	end

	// ************************************************************
	// Shift stages
	// ************************************************************
	for (genvar k = 1; k <= DEPTH; k++)
	begin : g_stage
		// Each stage holds the command one clock longer
		always_ff @(posedge clock)
		begin
			if (!rst_n)
			begin
				v_q[k] <= 1'b0;
				d_q[k] <= '0;
			end
			else
			begin
				v_q[k] <= (k == 1) ? in_valid : v_q[(k == 1) ? 1 : k - 1];
				d_q[k] <= (k == 1) ? in_data : d_q[(k == 1) ? 1 : k - 1];
			end
		end
	end

	// Zero delay passes straight through
	assign out_valid = (delay == 3'h0) ? in_valid : v_q[delay];
	assign out_data = (delay == 3'h0) ? in_data : d_q[delay];
endmodule : col_cmd_delay

// >>> hw/ddr_cmd_fsm.sv
// Command decoder and clock-enable power-state machine of a DDR2 memory core.
// Assumes pins come from an outside controller: each passes two flip-flops first.
`timescale 1ns/1ps

module ddr_cmd_fsm import ddr_cmd_pkg::*; #(
	parameter int ADDR_W = 14,
	parameter int DQ_W = 16,
	parameter int MAX_AL = 5,
	parameter int XSNR_CYCLES = XSNR_CYC,
	parameter int XSRD_CYCLES = T_XSRD_CLK,
	parameter int MRD_CYCLES = T_MRD_CLK
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [1:0] ba,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic odt,
	input wire logic wr_strobe,
	input wire logic [DQ_W-1:0] dq,
	input wire logic [DQ_W/8-1:0] dm,
	output logic [3:0] power_state,
	output logic [3:0] bank_open,
	output logic [ADDR_W-1:0] mode_reg0,
	output logic [ADDR_W-1:0] mode_reg1,
	output logic [ADDR_W-1:0] mode_reg2,
	output logic [ADDR_W-1:0] mode_reg3,
	output logic col_start,
	output logic col_write,
	output logic col_autopre,
	output logic [1:0] col_bank,
	output logic [COL_W-1:0] col_addr,
	output logic [ADDR_W-1:0] col_row,
	output logic [DQ_W/8-1:0] store_en,
	output logic [DQ_W-1:0] store_data,
	output logic odt_active,
	output logic illegal
);
	localparam int NB = DQ_W / 8;
	localparam int PW = 9 + ADDR_W + DQ_W + NB;
	localparam int CW = 4 + COL_W;

	if (DQ_W % 8 != 0 || ADDR_W < 11 || MAX_AL < 1 || MAX_AL > 7 || XSRD_CYCLES < 1
		|| XSRD_CYCLES > 255 || XSNR_CYCLES < 1 || XSNR_CYCLES > 255 || MRD_CYCLES < 1 || MRD_CYCLES > 255)
	begin : g_bad_param
		$error("ddr_cmd_fsm: unsupported parameter value");
	end

	function automatic logic is_quiet(input logic [3:0] c);
		return c[3] || (c == CMD_NOP);
	endfunction : is_quiet

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic [PW-1:0] pin_s1_q, pin_s2_q;
	logic c_cke, c_cs_n, c_ras_n, c_cas_n, c_we_n, c_odt, c_wstb;
	logic [1:0] c_ba;
	logic [ADDR_W-1:0] c_addr;
	logic [DQ_W-1:0] c_dq;
	logic [NB-1:0] c_dm;

	// Two stages before anything looks at the pins
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
		end
		else
		begin
			pin_s1_q <= {cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, wr_strobe, dq, dm};
			pin_s2_q <= pin_s1_q;
		end
	end
	assign {c_cke, c_cs_n, c_ras_n, c_cas_n, c_we_n, c_ba, c_addr, c_odt, c_wstb, c_dq, c_dm} = pin_s2_q;

	// ************************************************************
	// Command decode
	// ************************************************************
	pwr_state_t pwr_q, pwr_d;
	logic cke_p_q;
	logic [3:0] bank_open_q, bank_open_d;
	logic [ADDR_W-1:0] mr_q [0:3];
	logic [ADDR_W-1:0] row_q [0:3];
	logic [7:0] xsnr_cnt_q, xsrd_cnt_q, mrd_cnt_q;
	logic [1:0] hold_cnt_q;
	logic [2:0] burst_cnt_q;
	logic burst_ap_q;
	logic [1:0] burst_bank_q;
	logic [3:0] cmd;
	logic quiet, cke_rise, cke_fall, cke_hh, sel, all_idle, busy;
	logic is_mrs, is_ref, is_pre, is_act, is_rd, is_wr, is_col, blk_all, viol_cmd, ok, pd_viol;
	logic sref_go, exit_sref;

	assign cmd = {c_cs_n, c_ras_n, c_cas_n, c_we_n};
	assign quiet = is_quiet(cmd);
	assign cke_rise = !cke_p_q && c_cke;
	assign cke_fall = cke_p_q && !c_cke;
	assign cke_hh = cke_p_q && c_cke;
	assign sel = cke_hh && !quiet && (pwr_q == PW_ON);
	assign is_mrs = sel && (cmd == CMD_MRS);
	assign is_ref = sel && (cmd == CMD_REF);
	assign is_pre = sel && (cmd == CMD_PRE);
	assign is_act = sel && (cmd == CMD_ACT);
	assign is_rd = sel && (cmd == CMD_RD);
	assign is_wr = sel && (cmd == CMD_WR);
	assign is_col = is_rd || is_wr;
	assign all_idle = (bank_open_q == 4'h0);
	assign busy = (mrd_cnt_q != 8'h00) || (burst_cnt_q != 3'h0);
	assign blk_all = (xsnr_cnt_q != 8'h00) || (mrd_cnt_q != 8'h00);

	assign viol_cmd = sel && (blk_all || (is_rd && xsrd_cnt_q != 8'h00) || ((is_mrs || is_ref) && !all_idle)
		|| (is_act && bank_open_q[c_ba]) || (is_col && !bank_open_q[c_ba]) || !(is_mrs || is_ref || is_pre
		|| is_act || is_col));
	assign ok = sel && !viol_cmd;

	assign sref_go = (pwr_q == PW_ON) && cke_fall && (cmd == CMD_REF) && all_idle;
	assign exit_sref = (pwr_q == PW_SREF) && cke_rise;

	// flag unlisted enable and command mixes, early transitions and busy entry
	assign pd_viol = ((pwr_q == PW_ON) && cke_fall && (busy || (!quiet && !sref_go)))
		|| ((pwr_q != PW_ON) && cke_rise && !quiet)
		|| ((c_cke != cke_p_q) && (hold_cnt_q < 2'(CKE_MIN_CLK)));

	// ************************************************************
	// Power-state machine
	// ************************************************************
	// choose power-down flavour from open rows
	always_comb
	begin
		pwr_d = pwr_q;
		unique case (pwr_q)
			PW_ON:
			begin
				if (cke_fall && quiet)
					pwr_d = all_idle ? PW_PPD : PW_APD;
				else if (sref_go)
					pwr_d = PW_SREF;
			end
			PW_APD, PW_PPD, PW_SREF:
			begin
				if (cke_rise)
					pwr_d = PW_ON;
			end
		endcase
	end

	// State and previous enable level
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			pwr_q <= PW_ON;
			cke_p_q <= 1'b0;
		end
		else
		begin
			pwr_q <= pwr_d;
			cke_p_q <= c_cke;
		end
	end

	// count edges since last transition, saturating
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			hold_cnt_q <= 2'(CKE_MIN_CLK);
		else if (c_cke != cke_p_q)
			hold_cnt_q <= 2'h1;
		else if (hold_cnt_q < 2'(CKE_MIN_CLK))
			hold_cnt_q <= hold_cnt_q + 2'h1;
	end

	// ************************************************************
	// Interval timers
	// ************************************************************
	// exit intervals load on self-refresh exit
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			xsnr_cnt_q <= 8'h00;
			xsrd_cnt_q <= 8'h00;
			mrd_cnt_q <= 8'h00;
		end
		else
		begin
			xsnr_cnt_q <= exit_sref ? 8'(XSNR_CYCLES - 1) : xsnr_cnt_q - 8'(xsnr_cnt_q != 8'h00);
			xsrd_cnt_q <= exit_sref ? 8'(XSRD_CYCLES - 1) : xsrd_cnt_q - 8'(xsrd_cnt_q != 8'h00);
			mrd_cnt_q <= (ok && is_mrs) ? 8'(MRD_CYCLES - 1) : mrd_cnt_q - 8'(mrd_cnt_q != 8'h00);
		end
	end

	// ************************************************************
	// Mode registers and rows
	// ************************************************************
	// bank address picks the register
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			mr_q <= '{default: '0};
		else if (ok && is_mrs)
			mr_q[c_ba] <= c_addr;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			row_q <= '{default: '0};
		else if (ok && is_act)
			row_q[c_ba] <= c_addr;
	end

	// open on activate, close on precharge or auto precharge
	always_comb
	begin
		bank_open_d = bank_open_q;
		if (burst_cnt_q == 3'h1 && burst_ap_q)
			bank_open_d[burst_bank_q] = 1'b0;
		if (ok && is_act)
			bank_open_d[c_ba] = 1'b1;
		if (ok && is_pre)
		begin
			if (c_addr[AUTO_PRE_BIT])
				bank_open_d = 4'h0;
			else
				bank_open_d[c_ba] = 1'b0;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			bank_open_q <= 4'h0;
		else
			bank_open_q <= bank_open_d;
	end

	// ************************************************************
	// Column commands through additive latency
	// ************************************************************
	logic [2:0] al_raw, al_sel;
	logic dl_valid;
	logic [CW-1:0] dl_data;
	logic dl_wr, dl_ap;
	logic [1:0] dl_bank;
	logic [COL_W-1:0] dl_col;

	// Settings above the line's depth clip rather than alias
	assign al_raw = mr_q[MR_IDX_EMR1][MR_AL_LSB +: 3];
	assign al_sel = (al_raw > 3'(MAX_AL)) ? 3'(MAX_AL) : al_raw;

	// hold column command for the additive latency
	col_cmd_delay #(.W(CW), .DEPTH(MAX_AL)) u_delay (
		.clock(clock),
		.rst_n(rst_n),
		.in_valid(ok && is_col),
		.in_data({is_wr, c_addr[AUTO_PRE_BIT], c_ba, c_addr[COL_W-1:0]}),
		.delay(al_sel),
		.out_valid(dl_valid),
		.out_data(dl_data)
	);
	assign {dl_wr, dl_ap, dl_bank, dl_col} = dl_data;

	// start burst at column, track auto precharge
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			burst_cnt_q <= 3'h0;
			burst_ap_q <= 1'b0;
			burst_bank_q <= 2'h0;
		end
		else if (dl_valid)
		begin
			burst_cnt_q <= (mr_q[0][MR_BL_LSB +: 3] == MR_BL8_CODE) ? 3'(BURST_CLK_BL8) : 3'(BURST_CLK_BL4);
			burst_ap_q <= dl_ap;
			burst_bank_q <= dl_bank;
		end
		else if (burst_cnt_q != 3'h0)
			burst_cnt_q <= burst_cnt_q - 3'h1;
	end

	// Registered column outputs
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			col_start <= 1'b0;
			col_write <= 1'b0;
			col_autopre <= 1'b0;
			col_bank <= 2'h0;
			col_addr <= '0;
			col_row <= '0;
		end
		else
		begin
			col_start <= dl_valid;
			col_write <= dl_valid ? dl_wr : col_write;
			col_autopre <= dl_valid ? dl_ap : col_autopre;
			col_bank <= dl_valid ? dl_bank : col_bank;
			col_addr <= dl_valid ? dl_col : col_addr;
			col_row <= dl_valid ? row_q[dl_bank] : col_row;
		end
	end

	// ************************************************************
	// Write data mask, termination and status
	// ************************************************************
	// mask high inhibits the byte
	for (genvar b = 0; b < NB; b++)
	begin : g_byte
		always_ff @(posedge clock)
		begin
			if (!rst_n)
			begin
				store_en[b] <= 1'b0;
				store_data[8*b +: 8] <= 8'h00;
			end
			else
			begin
				store_en[b] <= c_wstb && !c_dm[b];
				store_data[8*b +: 8] <= c_wstb ? c_dq[8*b +: 8] : store_data[8*b +: 8];
			end
		end
	end

	// Status flops
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			odt_active <= 1'b0;
			illegal <= 1'b0;
		end
		else
		begin
			odt_active <= c_odt && (pwr_d != PW_SREF)
				&& (mr_q[MR_IDX_EMR1][MR_ODT_BIT_LO] || mr_q[MR_IDX_EMR1][MR_ODT_BIT_HI]);
			illegal <= viol_cmd || pd_viol;
		end
	end

	assign power_state = pwr_q;
	assign bank_open = bank_open_q;
	assign mode_reg0 = mr_q[0];
	assign mode_reg1 = mr_q[1];
	assign mode_reg2 = mr_q[2];
	assign mode_reg3 = mr_q[3];

	// ************************************************************
	// Assertions
	// ************************************************************
	property p_sref_entry;
		@(posedge clock) disable iff (!rst_n) sref_go |=> (pwr_q == PW_SREF);
	endproperty
	a_sref_entry: assert property (p_sref_entry) else $error("self refresh not entered");

	property p_pd_kind;
		@(posedge clock) disable iff (!rst_n)
		((pwr_q == PW_ON) && cke_fall && quiet) |=> (pwr_q == ($past(all_idle) ? PW_PPD : PW_APD));
	endproperty
	a_pd_kind: assert property (p_pd_kind) else $error("wrong power-down kind");

	property p_desel_idle;
		@(posedge clock) disable iff (!rst_n) c_cs_n |=> $stable(mr_q[1]) && !$past(ok);
	endproperty
	a_desel_idle: assert property (p_desel_idle) else $error("deselect changed state");

	// edges since the last self-refresh exit, counted apart from the blocking timer
	logic [7:0] since_exit_q;
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			since_exit_q <= 8'hFF;
		else if (exit_sref)
			since_exit_q <= 8'h00;
		else if (since_exit_q != 8'hFF)
			since_exit_q <= since_exit_q + 8'h01;
	end

	property p_read_block;
		@(posedge clock) disable iff (!rst_n) (ok && is_rd) |-> (since_exit_q >= 8'(XSRD_CYCLES - 1));
	endproperty
	a_read_block: assert property (p_read_block) else $error("read accepted right after exit");

	property p_mrs_load;
		@(posedge clock) disable iff (!rst_n) (ok && is_mrs && c_ba == 2'h2) |=> (mode_reg2 == $past(c_addr));
	endproperty
	a_mrs_load: assert property (p_mrs_load) else $error("mode register not loaded");

	property p_mrd_gap;
		@(posedge clock) disable iff (!rst_n) (ok && is_mrs) |=> !ok;
	endproperty
	a_mrd_gap: assert property (p_mrd_gap) else $error("command inside mode-set time");

	property p_act_open;
		@(posedge clock) disable iff (!rst_n) (ok && is_act) |=> bank_open[$past(c_ba)];
	endproperty
	a_act_open: assert property (p_act_open) else $error("activate did not open bank");

	property p_al2;
		@(posedge clock) disable iff (!rst_n) (ok && is_col && al_sel == 3'h2) |-> ##3 col_start;
	endproperty
	a_al2: assert property (p_al2) else $error("additive latency delay wrong");

	property p_odt_sref;
		@(posedge clock) disable iff (!rst_n) (pwr_q == PW_SREF) |-> !odt_active;
	endproperty
	a_odt_sref: assert property (p_odt_sref) else $error("termination on in self refresh");

	property p_mask;
		@(posedge clock) disable iff (!rst_n) (c_wstb && c_dm[0]) |=> !store_en[0];
	endproperty
	a_mask: assert property (p_mask) else $error("masked byte stored");
endmodule : ddr_cmd_fsm

// >>> bench/ddr_ctrl_model.sv
// Far-side memory controller model: turns bench requests into command pins.
// Assumes the bench changes its requests just after the falling clock edge.
`timescale 1ns/1ps
module ddr_ctrl_model import ddr_cmd_pkg::*; (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic want_cke,
	input wire logic [3:0] want_cmd,
	input wire logic [1:0] want_ba,
	input wire logic [13:0] want_addr,
	output logic cke,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [1:0] ba,
	output logic [13:0] addr
);
	logic cke_q;
	logic [1:0] held_q;
	logic [15:0] junk_q;
	logic [3:0] cmd;

	assign cke = (held_q == 2'h3) ? want_cke : cke_q;
	assign cmd = (cke != cke_q && !(want_cmd == CMD_REF && !cke)) ? CMD_NOP : want_cmd;
	// Deselected pins wander, so a stale value is never mistaken for a command
	assign {cs_n, ras_n, cas_n, we_n} = cmd[3] ? {1'b1, junk_q[2:0]} : cmd;
	assign ba = cmd[3] ? junk_q[4:3] : want_ba;
	assign addr = cmd[3] ? junk_q[13:0] : want_addr;

	// Edges seen at the present enable level, saturating at three
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			cke_q <= 1'b0;
			held_q <= 2'h3;
			junk_q <= 16'h5A3C;
		end
		else
		begin
			cke_q <= cke;
			held_q <= (cke != cke_q) ? 2'h1 : ((held_q == 2'h3) ? held_q : held_q + 2'h1);
			junk_q <= {junk_q[14:0], ~junk_q[15]};
		end
	end
endmodule : ddr_ctrl_model

// >>> bench/tb_sdram_cke_power_and_command_fsm.sv
// Self-checking bench for the command and power-state logic.
// Assumes the controller model on the pins; results lag pins by three edges.
`timescale 1ns/1ps
module tb_sdram_cke_power_and_command_fsm import ddr_cmd_pkg::*;;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic want_cke = 1'b0;
	logic [3:0] want_cmd = CMD_NOP;
	logic [1:0] want_ba = 2'h0;
	logic [13:0] want_addr = 14'h0000;
	logic odt = 1'b1;
	logic wr_strobe = 1'b0;
	logic [15:0] dq = 16'h0000;
	logic [1:0] dm = 2'h0;
	logic cke, cs_n, ras_n, cas_n, we_n, col_start, col_write, col_autopre, odt_active, illegal;
	logic [1:0] ba, col_bank, store_en;
	logic [13:0] addr, mode_reg0, mode_reg1, mode_reg2, mode_reg3, col_row, a;
	logic [13:0] exp_mr[4];
	logic [3:0] power_state, bank_open;
	logic [9:0] col_addr;
	logic [15:0] store_data;
	logic [31:0] seed = 32'hBA7961FA;
	logic [31:0] notes[$];
	logic [31:0] stores[$];
	int err_total = 0;
	int comparisons = 0;
	int ill_cnt = 0;
	int cycles = 0;

	always #12.5 clock = ~clock;

	ddr_ctrl_model MODEL (.clock(clock), .rst_n(rst_n), .want_cke(want_cke), .want_cmd(want_cmd),
		.want_ba(want_ba), .want_addr(want_addr), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr));

	// Short exit timers keep the run brief
	ddr_cmd_fsm #(.XSNR_CYCLES(2), .XSRD_CYCLES(10)) DUT (.clock(clock), .rst_n(rst_n), .cke(cke),
		.cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .odt(odt),
		.wr_strobe(wr_strobe), .dq(dq), .dm(dm), .power_state(power_state), .bank_open(bank_open),
		.mode_reg0(mode_reg0), .mode_reg1(mode_reg1), .mode_reg2(mode_reg2), .mode_reg3(mode_reg3),
		.col_start(col_start), .col_write(col_write), .col_autopre(col_autopre), .col_bank(col_bank),
		.col_addr(col_addr), .col_row(col_row), .store_en(store_en), .store_data(store_data),
		.odt_active(odt_active), .illegal(illegal));

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic test_done;
		if (err_total == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done

	// One command cycle, then quiet cycles up to n in all
	task automatic op(input logic [3:0] c, input logic [1:0] b, input logic [13:0] ad, input int n);
		want_cmd = c;
		want_ba = b;
		want_addr = ad;
		@(negedge clock);
		want_cmd = CMD_NOP;
		repeat (n - 1) @(negedge clock);
	endtask : op

	// Pulses are taken off the queues as they appear; the timeout also lives here
	always @(posedge clock)
	begin
		cycles++;
		if (illegal === 1'b1)
			ill_cnt++;
		if (col_start === 1'b1)
			check("column command", (notes.size() > 0) ? notes.pop_front() : 32'hFFFFFFFF,
				{18'h0, col_write, col_bank, col_autopre, col_addr});
		if (store_en !== 2'h0)
			check("stored byte", (stores.size() > 0) ? stores.pop_front() : 32'hFFFFFFFF,
				{14'h0, store_en, store_data & {{8{store_en[1]}}, {8{store_en[0]}}}});
		if (cycles > 1000)
		begin
			err_total++;
			test_done();
		end
	end

	initial
	begin
		repeat (20) @(negedge clock);
		rst_n = 1'b1;
		want_cke = 1'b1;
		op(CMD_NOP, 2'h0, 14'h0000, 5);
		check("power_state", PW_ON, power_state);
		// mode sets spaced beyond the cycle time, all banks idle
		for (int i = 0; i < 4; i++)
		begin
			seed = lfsr(seed);
			a = seed[13:0];
			if (i == 0)
				a[2:0] = 3'h2;
			if (i == 1)
				a[6:2] = 5'h01;
			exp_mr[i] = a;
			op(CMD_MRS, 2'(i), a, 3);
		end
		repeat (2) @(negedge clock);
		check("mode_reg0", exp_mr[0], mode_reg0);
		check("mode_reg1", exp_mr[1], mode_reg1);
		check("mode_reg2", exp_mr[2], mode_reg2);
		check("mode_reg3", exp_mr[3], mode_reg3);
		check("odt_active", 1'b1, odt_active);
		odt = 1'b0;
		repeat (4) @(negedge clock);
		check("odt_active", 1'b0, odt_active);
		odt = 1'b1;
		seed = lfsr(seed);
		op(CMD_ACT, 2'h2, seed[13:0], 5);
		check("bank_open", 4'h4, bank_open);
		op(4'h8, 2'h0, 14'h0000, 3);
		op(CMD_NOP, 2'h1, 14'h0000, 5);
		check("bank_open", 4'h4, bank_open);
		check("illegal count", 0, ill_cnt);
		notes.push_back({19'h0, 2'h2, 1'b1, seed[25:16]});
		op(CMD_RD, 2'h2, {3'h0, 1'b1, seed[25:16]}, 8);
		check("bank_open", 4'h0, bank_open);
		check("col_row", seed[13:0], col_row);
		op(CMD_RD, 2'h2, 14'h0000, 5);
		check("illegal count", 1, ill_cnt);
		// Strobe stays up across the four data beats
		wr_strobe = 1'b1;
		for (int d = 0; d < 4; d++)
		begin
			seed = lfsr(seed);
			if (d != 3)
				stores.push_back({14'h0, ~2'(d), seed[15:0] & {{8{~d[1]}}, {8{~d[0]}}}});
			dq = seed[15:0];
			dm = 2'(d);
			@(negedge clock);
		end
		wr_strobe = 1'b0;
		op(CMD_MRS, 2'h1, 14'h0014, 3);
		op(CMD_ACT, 2'h1, seed[29:16], 2);
		notes.push_back({19'h0, 2'h1, 1'b0, seed[9:0]});
		op(CMD_RD, 2'h1, {4'h0, seed[9:0]}, 10);
		check("bank_open", 4'h2, bank_open);
		notes.push_back({18'h0, 1'b1, 2'h1, 1'b0, 10'h2A5});
		op(CMD_WR, 2'h1, 14'h02A5, 10);
		check("col_row", seed[29:16], col_row);
		check("bank_open", 4'h2, bank_open);
		want_cke = 1'b0;
		op(CMD_NOP, 2'h0, 14'h0000, 5);
		check("power_state", PW_APD, power_state);
		want_cke = 1'b1;
		op(CMD_NOP, 2'h0, 14'h0000, 5);
		check("power_state", PW_ON, power_state);
		op(CMD_PRE, 2'h0, 14'h0400, 5);
		want_cke = 1'b0;
		op(CMD_NOP, 2'h0, 14'h0000, 5);
		check("power_state", PW_PPD, power_state);
		want_cke = 1'b1;
		op(CMD_NOP, 2'h0, 14'h0000, 5);
		want_cke = 1'b0;
		op(CMD_REF, 2'h0, 14'h0000, 5);
		check("power_state", PW_SREF, power_state);
		check("odt_active", 1'b0, odt_active);
		// early read on purpose, then a read after the wait
		want_cke = 1'b1;
		op(CMD_NOP, 2'h0, 14'h0000, 3);
		op(CMD_ACT, 2'h3, 14'h0123, 2);
		op(CMD_RD, 2'h3, 14'h0000, 14);
		check("illegal count", 2, ill_cnt);
		notes.push_back({19'h0, 2'h3, 1'b0, 10'h000});
		op(CMD_RD, 2'h3, 14'h0000, 10);
		check("illegal count", 2, ill_cnt);
		check("notes left", 0, notes.size() + stores.size());
		test_done();
	end
endmodule : tb_sdram_cke_power_and_command_fsm
